//--- src/spwd_sequencer.sv
// Scan sequencer and output units: loads configuration, streams samples to the
// detector, applies its updates, and appends the status word to each scan.
// Assumes user-side inputs come from logic on the same clock.
`timescale 1ns/100ps
module spwd_sequencer (
    input wire logic clk,
    input wire logic rst,
    spwd_link_if.sequencer link,
    input wire logic cfg_we,
    input wire logic [3:0] cfg_sp,
    input wire logic [2:0] cfg_field,
    input wire logic [15:0] cfg_data,
    input wire logic arm,
    input wire logic disarm,
    input wire logic smp_valid,
    input wire logic [3:0] smp_sp,
    input wire logic [15:0] smp_data,
    input wire logic smp_is_counter,
    input wire logic [31:0] smp_count,
    input wire logic smp_high_half,
    input wire logic scan_end,
    input wire logic port_init_we,
    input wire logic [7:0] port_init_data,
    output logic entry_valid,
    output logic [15:0] entry_data,
    output logic [7:0] fast_update_port,
    output logic port_oe,
    output logic [15:0] analog_output_zero,
    output logic [15:0] analog_output_one,
    output logic [15:0] analog_output_two,
    output logic [15:0] timer_output_zero
);

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    spwd_pkg::spwd_seq_t state;
    spwd_pkg::spwd_seq_t next_state;
    logic armed;

    // Arming starts evaluation at once; trigger handling is outside this end.
    always_comb begin
        case (state)
            spwd_pkg::SPWD_SEQ_IDLE: next_state = arm ? spwd_pkg::SPWD_SEQ_ARMED : state;
            spwd_pkg::SPWD_SEQ_ARMED: next_state = scan_end ? spwd_pkg::SPWD_SEQ_DRAIN : state;
            spwd_pkg::SPWD_SEQ_DRAIN: next_state = spwd_pkg::SPWD_SEQ_EMIT;
            spwd_pkg::SPWD_SEQ_EMIT: next_state = spwd_pkg::SPWD_SEQ_ARMED;
            default: next_state = spwd_pkg::SPWD_SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || disarm) begin
            state <= spwd_pkg::SPWD_SEQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Drive the link from flops
    // ------------------------------------------------------------------
    // Counter words are cut to the chosen half before comparison.
    wire [15:0] cnt_half = smp_high_half ? smp_count[31:16] : smp_count[15:0];
    wire [15:0] smp_word = smp_is_counter ? cnt_half : smp_data;
    wire take_smp = smp_valid && (state == spwd_pkg::SPWD_SEQ_ARMED);
    wire next_armed = (state != spwd_pkg::SPWD_SEQ_IDLE) || arm;

    always_ff @(posedge clk) begin
        if (rst) begin
            armed <= 1'b0;
            link.cfg_we <= 1'b0;
            link.cfg_sp <= 4'h0;
            link.cfg_field <= 3'h0;
            link.cfg_data <= spwd_pkg::SPWD_ZERO16;
            link.smp_valid <= 1'b0;
            link.smp_sp <= 4'h0;
            link.smp_data <= spwd_pkg::SPWD_ZERO16;
        end else begin
            armed <= next_armed && !disarm;
            link.cfg_we <= cfg_we && !next_armed; // No setup once a run begins.
            link.cfg_sp <= cfg_sp;
            link.cfg_field <= cfg_field;
            link.cfg_data <= cfg_data;
            link.smp_valid <= take_smp;
            link.smp_sp <= smp_sp;
            link.smp_data <= smp_word;
        end
    end
    assign link.armed = armed;

    // ------------------------------------------------------------------
    // Acquisition stream with the status word last
    // ------------------------------------------------------------------
    // The drain cycle lets the detector's flag for the final channel settle first.
    always_ff @(posedge clk) begin
        if (rst) begin
            entry_valid <= 1'b0;
            entry_data <= spwd_pkg::SPWD_ZERO16;
        end else if (state == spwd_pkg::SPWD_SEQ_EMIT) begin
            entry_valid <= 1'b1;
            entry_data <= link.setpoint_state_bits;
        end else begin
            entry_valid <= take_smp;
            entry_data <= smp_word;
        end
    end

    // ------------------------------------------------------------------
    // Output units
    // ------------------------------------------------------------------
    wire [7:0] p_dat = link.upd_data[spwd_pkg::SPWD_PORT_DATA_LSB +: spwd_pkg::SPWD_BYTE_W];
    wire [7:0] p_msk = link.upd_data[spwd_pkg::SPWD_PORT_MASK_LSB +: spwd_pkg::SPWD_BYTE_W];
    wire port_upd = link.upd_valid && (link.upd_target == spwd_pkg::SPWD_TGT_PORT);
    wire [7:0] port_merge = (fast_update_port & ~p_msk) | (p_dat & p_msk);

    // The port stays an input until software writes an initial value.
    always_ff @(posedge clk) begin
        if (rst) begin
            fast_update_port <= spwd_pkg::SPWD_ZERO8;
            port_oe <= 1'b0;
        end else if (port_init_we) begin
            fast_update_port <= port_init_data;
            port_oe <= 1'b1;
        end else if (port_upd) begin
            fast_update_port <= port_merge;
        end
    end

    // Analog and timer outputs take the whole 16-bit update value.
    always_ff @(posedge clk) begin
        if (rst) begin
            analog_output_zero <= spwd_pkg::SPWD_ZERO16;
            analog_output_one <= spwd_pkg::SPWD_ZERO16;
            analog_output_two <= spwd_pkg::SPWD_ZERO16;
            timer_output_zero <= spwd_pkg::SPWD_ZERO16;
        end else if (link.upd_valid) begin
            case (link.upd_target)
                spwd_pkg::SPWD_TGT_ANA0: analog_output_zero <= link.upd_data;
                spwd_pkg::SPWD_TGT_ANA1: analog_output_one <= link.upd_data;
                spwd_pkg::SPWD_TGT_ANA2: analog_output_two <= link.upd_data;
                spwd_pkg::SPWD_TGT_TMR0: timer_output_zero <= link.upd_data;
                default: ;
            endcase
        end
    end

endmodule

//--- src/spwd_pkg.sv
// Package for the setpoint window detector: field codes, criteria, targets, widths.
// Assumes both ends and the bench compile it first.
package spwd_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int SPWD_DATA_W = 16;
    localparam int SPWD_NUM_SP = 16;
    localparam int SPWD_IDX_W = 4;
    localparam int SPWD_BYTE_W = 8;
    localparam int SPWD_CNT_W = 32;

    // ------------------------------------------------------------------
    // Configuration field codes on the write port
    // ------------------------------------------------------------------
    localparam logic [2:0] SPWD_FLD_UPPER = 3'h0;
    localparam logic [2:0] SPWD_FLD_LOWER = 3'h1;
    localparam logic [2:0] SPWD_FLD_CRIT = 3'h2;
    localparam logic [2:0] SPWD_FLD_TARGET = 3'h3;
    localparam logic [2:0] SPWD_FLD_MODE = 3'h4;
    localparam logic [2:0] SPWD_FLD_VAL1 = 3'h5;
    localparam logic [2:0] SPWD_FLD_VAL2 = 3'h6;

    // ------------------------------------------------------------------
    // Comparison criteria
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SPWD_CRIT_INSIDE = 3'h0,
        SPWD_CRIT_OUTSIDE = 3'h1,
        SPWD_CRIT_GREATER = 3'h2,
        SPWD_CRIT_LESS = 3'h3,
        SPWD_CRIT_EQUAL = 3'h4,
        SPWD_CRIT_HYST = 3'h5
    } spwd_crit_t;

    // Update modes.
    localparam logic SPWD_MODE_TRUE_ONLY = 1'h0;
    localparam logic SPWD_MODE_TRUE_FALSE = 1'h1;

    // ------------------------------------------------------------------
    // Output targets
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SPWD_TGT_NONE = 3'h0,
        SPWD_TGT_PORT = 3'h1,
        SPWD_TGT_ANA0 = 3'h2,
        SPWD_TGT_ANA1 = 3'h3,
        SPWD_TGT_ANA2 = 3'h4,
        SPWD_TGT_TMR0 = 3'h5
    } spwd_target_t;
    localparam int SPWD_NUM_TGT = 6;

    // Port update value: low byte is data, high byte is the bit mask.
    localparam int SPWD_PORT_DATA_LSB = 0;
    localparam int SPWD_PORT_MASK_LSB = 8;

    // Reset values.
    localparam logic [15:0] SPWD_ZERO16 = 16'h0000;
    localparam logic [7:0] SPWD_ZERO8 = 8'h00;

    // Scan sequencer states, Gray coded along idle, armed, drain, emit.
    typedef enum logic [1:0] {
        SPWD_SEQ_IDLE = 2'h0,
        SPWD_SEQ_ARMED = 2'h1,
        SPWD_SEQ_DRAIN = 2'h3,
        SPWD_SEQ_EMIT = 2'h2
    } spwd_seq_t;

endpackage

//--- src/spwd_link_if.sv
// Interface joining the scan sequencer end and the setpoint detector end.
// Assumes one common clock; no clocking block.
`timescale 1ns/100ps
interface spwd_link_if (
    input wire logic clk
);
    logic armed;
    logic cfg_we;
    logic [3:0] cfg_sp;
    logic [2:0] cfg_field;
    logic [15:0] cfg_data;
    logic smp_valid;
    logic [3:0] smp_sp;
    logic [15:0] smp_data;
    logic upd_valid;
    logic [2:0] upd_target;
    logic [15:0] upd_data;
    logic [15:0] setpoint_state_bits;

    modport detector (
        input armed, cfg_we, cfg_sp, cfg_field, cfg_data, smp_valid, smp_sp, smp_data,
        output upd_valid, upd_target, upd_data, setpoint_state_bits
    );
    modport sequencer (
        output armed, cfg_we, cfg_sp, cfg_field, cfg_data, smp_valid, smp_sp, smp_data,
        input upd_valid, upd_target, upd_data, setpoint_state_bits
    );
endinterface

//--- src/spwd_detector.sv
// Setpoint window detector: sixteen setpoints compare scan samples against limits
// and issue updates for the fast port, analog and timer outputs.
// Assumes the sequencer end delivers one sample per cycle tagged with its setpoint.
//
// Function
// - Each setpoint holds upper and lower limits.
// - Configuration loaded before run, frozen while armed.
// - Inside: lower < sample < upper.
// - Outside: sample above upper or below lower.
// - Greater: sample above lower; upper ignored.
// - Less: sample below upper; lower ignored.
// - Equal: sample equals upper; lower ignored.
// - Equal criterion only for counter/digital sources; not checked, any sample code is compared.
// - Hysteresis: above forces value two, below value one.
// - First value written to chosen target when true.
// - True-and-false mode writes second value when false.
// - True-only mode leaves target alone when false.
// - Shared output follows most recently true setpoint; false writes and hysteresis writes still overwrite the owner.
// - Evaluation starts at arming, not at trigger.
// - Status word bit i is setpoint i.
// - Status bit is one exactly while condition true.
// - Status word is last scan list entry.
// - Counter setpoints compare a selected 16-bit half.
// - Fast port resets as input; initialise before scanning.
// - Match flag changes at most once per scan.
// - At most sixteen setpoints, one per channel.
// - Port update writes data through a mask.
`timescale 1ns/100ps
module spwd_detector (
    input wire logic clk,
    input wire logic rst,
    spwd_link_if.detector link
);

    // ------------------------------------------------------------------
    // Configuration store
    // ------------------------------------------------------------------
    // A four-bit index caps the store at sixteen setpoints.
    logic [15:0] upper_lim [spwd_pkg::SPWD_NUM_SP];
    logic [15:0] lower_lim [spwd_pkg::SPWD_NUM_SP];
    spwd_pkg::spwd_crit_t crit [spwd_pkg::SPWD_NUM_SP];
    spwd_pkg::spwd_target_t target [spwd_pkg::SPWD_NUM_SP];
    logic mode [spwd_pkg::SPWD_NUM_SP];
    logic [15:0] val1 [spwd_pkg::SPWD_NUM_SP];
    logic [15:0] val2 [spwd_pkg::SPWD_NUM_SP];

    // Per-setpoint condition flags and owner of each target.
    logic [15:0] channel_match_flag;
    logic [3:0] owner [spwd_pkg::SPWD_NUM_TGT];
    // Registered update path toward the output units.
    logic upd_valid;
    spwd_pkg::spwd_target_t upd_target;
    logic [15:0] upd_data;

    // ------------------------------------------------------------------
    // Comparison of the current sample
    // ------------------------------------------------------------------
    // Fields of the sample now on the link.
    wire [3:0] idx = link.smp_sp;
    wire [15:0] x = link.smp_data; // Raw code, whatever it stands for.

    // Limits of the setpoint being sampled.
    wire [15:0] hi = upper_lim[idx];
    wire [15:0] lo = lower_lim[idx];

    // Strict: a sample equal to a limit is neither.
    wire above = x > hi;
    wire below = x < lo;

    // Last result, kept by hysteresis and ownership.
    wire old_flag = channel_match_flag[idx];
    wire is_hyst = crit[idx] == spwd_pkg::SPWD_CRIT_HYST;

    // Any sample in a run is judged; no trigger gate.
    wire eval = link.smp_valid && link.armed;

    // Target of the setpoint being sampled.
    spwd_pkg::spwd_target_t tgt;
    assign tgt = target[idx];
    logic cond;

    // Unused criterion codes never match; in true-and-false mode they still write the second value.
    // Criterion select; hysteresis keeps the flag while inside the window.
    always_comb begin
        case (crit[idx])
            spwd_pkg::SPWD_CRIT_INSIDE: cond = (x < hi) && (x > lo);
            spwd_pkg::SPWD_CRIT_OUTSIDE: cond = above || below;
            spwd_pkg::SPWD_CRIT_GREATER: cond = x > lo;
            spwd_pkg::SPWD_CRIT_LESS: cond = x < hi;
            spwd_pkg::SPWD_CRIT_EQUAL: cond = x == hi;
            spwd_pkg::SPWD_CRIT_HYST: cond = above ? 1'b1 : (below ? 1'b0 : old_flag);
            default: cond = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Update decision
    // ------------------------------------------------------------------
    // A true write passes if the condition is newly true or this setpoint already
    // owns the target, so a setpoint that stays true cannot steal the output back
    // from one that became true later.
    wire is_owner = owner[tgt] == idx;
    wire take_true = cond && (!old_flag || is_owner);
    wire take_false = !cond && (mode[idx] == spwd_pkg::SPWD_MODE_TRUE_FALSE);

    // Hysteresis ignores the update mode.
    wire hyst_write = above || below; // Forced update only outside the window.
    wire write_sel = is_hyst ? hyst_write : (take_true || take_false);

    // No target means no strobe.
    wire next_upd_valid = eval && write_sel && (tgt != spwd_pkg::SPWD_TGT_NONE);

    // Above picks the second value, below the first.
    wire [15:0] hyst_val = above ? val2[idx] : val1[idx];
    wire [15:0] next_upd_data = is_hyst ? hyst_val : (cond ? val1[idx] : val2[idx]);

    // Only a true write claims the target.
    wire claim = next_upd_valid && cond;

    // ------------------------------------------------------------------
    // Configuration writes, refused while armed
    // ------------------------------------------------------------------
    // Dropped, not queued: a run sees one setup.
    wire cfg_ok = link.cfg_we && !link.armed;

    // Limit, criterion and value registers; reset to zero, no target.
    // Criterion and target codes use the low three data bits.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < spwd_pkg::SPWD_NUM_SP; i++) begin
                upper_lim[i] <= spwd_pkg::SPWD_ZERO16;
                lower_lim[i] <= spwd_pkg::SPWD_ZERO16;
                crit[i] <= spwd_pkg::SPWD_CRIT_INSIDE;
                target[i] <= spwd_pkg::SPWD_TGT_NONE;
                mode[i] <= spwd_pkg::SPWD_MODE_TRUE_ONLY;
                val1[i] <= spwd_pkg::SPWD_ZERO16;
                val2[i] <= spwd_pkg::SPWD_ZERO16;
            end
        end else if (cfg_ok) begin
            case (link.cfg_field)
                spwd_pkg::SPWD_FLD_UPPER: upper_lim[link.cfg_sp] <= link.cfg_data;
                spwd_pkg::SPWD_FLD_LOWER: lower_lim[link.cfg_sp] <= link.cfg_data;
                spwd_pkg::SPWD_FLD_CRIT: begin
                    crit[link.cfg_sp] <= spwd_pkg::spwd_crit_t'(link.cfg_data[2:0]);
                end
                spwd_pkg::SPWD_FLD_TARGET: begin
                    target[link.cfg_sp] <= spwd_pkg::spwd_target_t'(link.cfg_data[2:0]);
                end
                spwd_pkg::SPWD_FLD_MODE: mode[link.cfg_sp] <= link.cfg_data[0];
                spwd_pkg::SPWD_FLD_VAL1: val1[link.cfg_sp] <= link.cfg_data;
                spwd_pkg::SPWD_FLD_VAL2: val2[link.cfg_sp] <= link.cfg_data;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Match flags and target ownership
    // ------------------------------------------------------------------
    // A flag moves only on its own sample, so at most once per scan; flags clear
    // while disarmed so every run starts from a false condition.
    // A disarm wins over a sample in the same cycle.
    always_ff @(posedge clk) begin
        if (rst || !link.armed) begin
            channel_match_flag <= spwd_pkg::SPWD_ZERO16;
        end else if (eval) begin
            channel_match_flag[idx] <= cond;
        end
    end

    // Owner of each target is the last setpoint that wrote it on a true result.
    // Owners clear with the flags at each disarm.
    always_ff @(posedge clk) begin
        if (rst || !link.armed) begin
            for (int t = 0; t < spwd_pkg::SPWD_NUM_TGT; t++) begin
                owner[t] <= 4'h0;
            end
        end else if (claim) begin
            owner[tgt] <= idx;
        end
    end

    // ------------------------------------------------------------------
    // Registered update strobe and status word
    // ------------------------------------------------------------------
    // Target and data move freely; only the strobe counts.
    always_ff @(posedge clk) begin
        if (rst) begin
            upd_valid <= 1'b0;
            upd_target <= spwd_pkg::SPWD_TGT_NONE;
            upd_data <= spwd_pkg::SPWD_ZERO16;
        end else begin
            upd_valid <= next_upd_valid;
            upd_target <= tgt;
            upd_data <= next_upd_data;
        end
    end

    // Setpoint i lands on bit i of the status word.
    assign link.setpoint_state_bits = channel_match_flag;

    // The update path leaves straight from its flops.
    assign link.upd_valid = upd_valid;
    assign link.upd_target = upd_target;
    assign link.upd_data = upd_data;

endmodule

//--- test/spwd_link_chk.sv
// Checker for the link between sequencer and detector ends.
// Assumes one clock and a synchronous active-high reset; instantiated beside the link.
`timescale 1ns/100ps
module spwd_link_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic armed,
    input wire logic cfg_we,
    input wire logic smp_valid,
    input wire logic [3:0] smp_sp,
    input wire logic upd_valid,
    input wire logic [2:0] upd_target,
    input wire logic [15:0] setpoint_state_bits
);
    // ------------------------------------------------------------------
    // Link properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // An update strobe is always the answer to the sample one cycle before.
    property p_upd_after_sample;
        upd_valid |-> $past(smp_valid);
    endproperty
    a_upd_after_sample: assert property (p_upd_after_sample)
        else $error("update strobe without a preceding sample");

    property p_no_upd_none;
        upd_valid |-> upd_target != spwd_pkg::SPWD_TGT_NONE;
    endproperty
    a_no_upd_none: assert property (p_no_upd_none)
        else $error("update strobe aimed at no target");

    property p_upd_target_range;
        upd_valid |-> upd_target <= spwd_pkg::SPWD_TGT_TMR0;
    endproperty
    a_upd_target_range: assert property (p_upd_target_range)
        else $error("update target code out of range");

    // Only the bit of the setpoint just sampled may move.
    property p_one_bit_moves;
        armed && $past(armed) |-> ((setpoint_state_bits ^ $past(setpoint_state_bits))
            & ~((16'h0001 << $past(smp_sp)) & {16{$past(smp_valid)}})) == 16'h0000;
    endproperty
    a_one_bit_moves: assert property (p_one_bit_moves)
        else $error("status bit moved without its own sample");

    property p_disarmed_clear;
        !armed && !$past(armed) && !$past(armed, 2) |-> setpoint_state_bits == 16'h0000;
    endproperty
    a_disarmed_clear: assert property (p_disarmed_clear)
        else $error("status bits set while disarmed");

    property p_cfg_idle;
        cfg_we |-> !armed;
    endproperty
    a_cfg_idle: assert property (p_cfg_idle)
        else $error("configuration write while armed");

    property p_upd_armed;
        upd_valid |-> $past(armed);
    endproperty
    a_upd_armed: assert property (p_upd_armed)
        else $error("update strobe outside a run");

    property p_smp_armed;
        smp_valid |-> $past(armed);
    endproperty
    a_smp_armed: assert property (p_smp_armed)
        else $error("sample forwarded outside a run");
endmodule

//--- test/setpoint_window_detector_tb.sv
// Self-checking bench: both ends joined by the link, driven on the sequencer user side.
// Assumes the package and link interface are compiled first.
`timescale 1ns/100ps
module setpoint_window_detector_tb;
    localparam logic [15:0] HI = 16'h1000;
    localparam logic [15:0] LO = 16'h0800;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_we, arm, disarm, smp_valid, smp_is_counter, smp_high_half, scan_end;
    logic [3:0] cfg_sp, smp_sp;
    logic [2:0] cfg_field;
    logic [15:0] cfg_data, smp_data, entry_data, ana0, ana1, ana2, tmr0, exp;
    logic [31:0] smp_count;
    logic port_init_we, entry_valid, port_oe;
    logic [7:0] port_init_data, fast_update_port;
    logic [15:0] vals [6] = '{16'h0800, 16'h0801, 16'h0fff, 16'h1000, 16'h1001, 16'h0000};
    int error_cnt = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    spwd_link_if link (.clk(clk));
    spwd_detector u_spwd_detector (.clk(clk), .rst(rst), .link(link));
    spwd_sequencer u_spwd_sequencer (.clk(clk), .rst(rst), .link(link), .cfg_we(cfg_we),
        .cfg_sp(cfg_sp), .cfg_field(cfg_field), .cfg_data(cfg_data), .arm(arm),
        .disarm(disarm), .smp_valid(smp_valid), .smp_sp(smp_sp), .smp_data(smp_data),
        .smp_is_counter(smp_is_counter), .smp_count(smp_count),
        .smp_high_half(smp_high_half), .scan_end(scan_end), .port_init_we(port_init_we),
        .port_init_data(port_init_data), .entry_valid(entry_valid), .entry_data(entry_data),
        .fast_update_port(fast_update_port), .port_oe(port_oe), .analog_output_zero(ana0),
        .analog_output_one(ana1), .analog_output_two(ana2), .timer_output_zero(tmr0));
    spwd_link_chk u_spwd_link_chk (.clk(clk), .rst(rst), .armed(link.armed),
        .cfg_we(link.cfg_we), .smp_valid(link.smp_valid), .smp_sp(link.smp_sp),
        .upd_valid(link.upd_valid), .upd_target(link.upd_target),
        .setpoint_state_bits(link.setpoint_state_bits));

    // ------------------------------------------------------------------
    // Access tasks and reference
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        n_checks++;
        if (got !== want) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cfg(input logic [3:0] sp, input logic [2:0] f, input logic [15:0] d);
        cfg_we = 1'b1;
        cfg_sp = sp;
        cfg_field = f;
        cfg_data = d;
        @(negedge clk);
        cfg_we = 1'b0;
        @(negedge clk);
    endtask

    task automatic setup(input logic [3:0] sp, input logic [2:0] cr, input logic [2:0] tg,
            input logic md, input logic [15:0] v1, input logic [15:0] v2);
        cfg(sp, spwd_pkg::SPWD_FLD_UPPER, HI);
        cfg(sp, spwd_pkg::SPWD_FLD_LOWER, LO);
        cfg(sp, spwd_pkg::SPWD_FLD_CRIT, {13'h0000, cr});
        cfg(sp, spwd_pkg::SPWD_FLD_TARGET, {13'h0000, tg});
        cfg(sp, spwd_pkg::SPWD_FLD_MODE, {15'h0000, md});
        cfg(sp, spwd_pkg::SPWD_FLD_VAL1, v1);
        cfg(sp, spwd_pkg::SPWD_FLD_VAL2, v2);
    endtask

    // Four idle edges after each sample let the output registers settle.
    task automatic smp(input logic [3:0] sp, input logic [15:0] d);
        smp_valid = 1'b1;
        smp_sp = sp;
        smp_data = d;
        @(negedge clk);
        smp_valid = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    function automatic logic cond(input int c, input logic [15:0] x);
        case (c)
            0: return (x < HI) && (x > LO);
            1: return (x > HI) || (x < LO);
            2: return x > LO;
            3: return x < HI;
            default: return x == HI;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {cfg_we, arm, disarm, smp_valid, smp_is_counter, smp_high_half, scan_end} = 7'h00;
        {cfg_sp, smp_sp, cfg_field, cfg_data, smp_data, smp_count} = 75'h0;
        port_init_we = 1'b0;
        port_init_data = 8'h00;
        exp = 16'h0000;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk({15'h0000, port_oe}, 16'h0000);
        // Setpoint 4 has the equal criterion with plain codes.
        for (int c = 0; c < 5; c++) begin
            setup(c[3:0], c[2:0], spwd_pkg::SPWD_TGT_NONE, 1'b0, 16'h0000, 16'h0000);
        end
        setup(4'h9, spwd_pkg::SPWD_CRIT_INSIDE, spwd_pkg::SPWD_TGT_NONE, 1'b0, 16'h0, 16'h0);
        pulse(arm);
        // Boundary codes around both limits exercise the strictness of every criterion except hysteresis.
        for (int i = 0; i < 6; i++) begin
            for (int c = 0; c < 5; c++) begin
                smp(c[3:0], vals[i]);
                exp[c] = cond(c, vals[i]);
            end
            chk(link.setpoint_state_bits, exp);
        end
        smp_is_counter = 1'b1;
        smp_count = 32'h0900_2000;
        smp_high_half = 1'b1;
        smp(4'h9, 16'h0000);
        chk(link.setpoint_state_bits, exp | 16'h0200);
        smp_high_half = 1'b0;
        smp(4'h9, 16'h0000);
        chk(link.setpoint_state_bits, exp);
        smp_is_counter = 1'b0;
        scan_end = 1'b1;
        @(negedge clk);
        scan_end = 1'b0;
        for (int w = 0; w < 8 && entry_valid !== 1'b1; w++) begin
            @(negedge clk);
        end
        chk(entry_data, exp);
        chk({15'h0000, entry_valid}, 16'h0001);
        pulse(disarm);
        setup(4'h5, spwd_pkg::SPWD_CRIT_INSIDE, spwd_pkg::SPWD_TGT_ANA1, 1'b1, 16'h1234,
            16'habcd);
        setup(4'h8, spwd_pkg::SPWD_CRIT_INSIDE, spwd_pkg::SPWD_TGT_ANA1, 1'b0, 16'h5555,
            16'h7777);
        setup(4'h6, spwd_pkg::SPWD_CRIT_HYST, spwd_pkg::SPWD_TGT_TMR0, 1'b0, 16'h0011,
            16'h0022);
        setup(4'h7, spwd_pkg::SPWD_CRIT_INSIDE, spwd_pkg::SPWD_TGT_PORT, 1'b0, 16'h0fa5,
            16'hff00);
        port_init_data = 8'h3c;
        pulse(port_init_we);
        chk({port_oe, 7'h00, fast_update_port}, 16'h803c);
        pulse(arm);
        smp(4'h7, 16'h0900);
        chk({8'h00, fast_update_port}, 16'h0035);
        smp(4'h7, 16'h0000);
        chk({8'h00, fast_update_port}, 16'h0035);
        smp(4'h5, 16'h0900);
        chk(ana1, 16'h1234);
        smp(4'h8, 16'h0900);
        smp(4'h5, 16'h0900);
        chk(ana1, 16'h5555);
        smp(4'h5, 16'h2000);
        chk(ana1, 16'habcd);
        smp(4'h8, 16'h2000);
        chk(ana1, 16'habcd);
        // A write while armed must be dropped, so the old first value returns.
        cfg(4'h5, spwd_pkg::SPWD_FLD_VAL1, 16'hffff);
        smp(4'h5, 16'h0900);
        chk(ana1, 16'h1234);
        chk(ana0 | ana2, 16'h0000);
        smp(4'h6, 16'h1001);
        chk(tmr0, 16'h0022);
        smp(4'h6, 16'h0900);
        chk(tmr0, 16'h0022);
        smp(4'h6, 16'h07ff);
        chk(tmr0, 16'h0011);
        smp(4'h6, 16'h0900);
        chk(tmr0, 16'h0011);
        pulse(disarm);
        print_verdict();
    end

    // The sequence needs well under 1000 cycles; this bound only cuts a hang.
    initial begin
        #50000;
        error_cnt++;
        print_verdict();
    end
endmodule
